// [common/fcsm_pkg.sv]
// Purpose: shared constants of the flash command sequencer host
// Assumes: 100 MHz clock, 16-bit flash data, 19 address pins
// Notes:   offsets are byte addresses on an APB bus with 32-bit data
package fcsm_pkg;
  // clock and bus-cycle timing (least times, rounded up)
  localparam int CLK_NS      = 10;
  localparam int T_SETUP_NS  = 10;
  localparam int T_WP_NS     = 35;
  localparam int T_ACC_NS    = 70;
  localparam int T_HOLD_NS   = 20;
  localparam int T_SUSP_US   = 20;
  localparam int T_SETUP_CYC = (T_SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int T_WP_CYC    = (T_WP_NS + CLK_NS - 1) / CLK_NS;
  localparam int T_ACC_CYC   = (T_ACC_NS + CLK_NS - 1) / CLK_NS;
  localparam int T_HOLD_CYC  = (T_HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam int T_SUSP_CYC  = (T_SUSP_US * 1000 + CLK_NS - 1) / CLK_NS;

  // register byte offsets
  localparam logic [7:0] REG_CTRL  = 8'h00;
  localparam logic [7:0] REG_ADDR  = 8'h04;
  localparam logic [7:0] REG_WDATA = 8'h08;
  localparam logic [7:0] REG_STAT  = 8'h0c;
  localparam logic [7:0] REG_RDATA = 8'h10;

  // control fields: op code and byte-mode select
  localparam int CTRL_OP_LSB = 0;
  localparam int CTRL_BYTE   = 4;
  localparam logic [4:0] CTRL_RST = 5'h00;

  // status bits
  localparam int ST_BUSY    = 0;
  localparam int ST_ERR     = 1;
  localparam int ST_REFUSED = 2;
  localparam int ST_BYPASS  = 3;
  localparam int ST_IDENT   = 4;
  localparam int ST_SUSP    = 5;
  localparam int ST_ERASING = 6;

  // host operation codes written to the control register
  localparam logic [3:0] OP_READ   = 4'h0;
  localparam logic [3:0] OP_RESET  = 4'h1;
  localparam logic [3:0] OP_IDENT  = 4'h2;
  localparam logic [3:0] OP_PROG   = 4'h3;
  localparam logic [3:0] OP_BYP_EN = 4'h4;
  localparam logic [3:0] OP_BYP_EX = 4'h5;
  localparam logic [3:0] OP_CHIP   = 4'h6;
  localparam logic [3:0] OP_SECTOR = 4'h7;
  localparam logic [3:0] OP_SUSP   = 4'h8;
  localparam logic [3:0] OP_RESUME = 4'h9;
  localparam logic [3:0] OP_POLL   = 4'ha;

  // flash command codes
  localparam logic [15:0] CMD_RESET   = 16'h00f0;
  localparam logic [15:0] CMD_SUSP    = 16'h00b0;
  localparam logic [15:0] CMD_RESUME  = 16'h0030;
  localparam logic [15:0] CMD_PROG    = 16'h00a0;
  localparam logic [15:0] CMD_IDENT   = 16'h0090;
  localparam logic [15:0] CMD_ESETUP  = 16'h0080;
  localparam logic [15:0] CMD_CHIP    = 16'h0010;
  localparam logic [15:0] CMD_SECTOR  = 16'h0030;
  localparam logic [15:0] CMD_BYP_EN  = 16'h0020;
  localparam logic [15:0] CMD_BYP_EX0 = 16'h0090;
  localparam logic [15:0] CMD_BYP_EX1 = 16'h0000;
  localparam logic [15:0] UNLOCK1     = 16'h00aa;
  localparam logic [15:0] UNLOCK2     = 16'h0055;

  // unlock addresses in word and byte mode
  localparam logic [18:0] UA1_WORD = 19'h00555;
  localparam logic [18:0] UA2_WORD = 19'h002aa;
  localparam logic [18:0] UA1_BYTE = 19'h00aaa;
  localparam logic [18:0] UA2_BYTE = 19'h00555;

  // status bit positions on the flash data bus
  localparam int DQ_TOGGLE  = 6;
  localparam int DQ_TLIMIT  = 5;
endpackage

// [design/fcsm_bus_cycle.sv]
// Purpose: one asynchronous flash read or write cycle on the pins
// Assumes: pin inputs are synchronous to clk
// Notes:   chip enable frames the strobe so we/oe edges decide latching
`timescale 1ns/10ps
`default_nettype none
module fcsm_bus_cycle
  import fcsm_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // request from the sequencer
  input  wire logic        start,
  input  wire logic        wr,
  input  wire logic [18:0] addr,
  input  wire logic [15:0] wdata,
  output logic             done,
  output logic [15:0]      rdata,
  // flash pins
  output logic [18:0]      fl_addr,
  output logic [15:0]      fl_dq_out,
  output logic             fl_dq_oe_n,
  input  wire logic [15:0] fl_dq_in,
  output logic             fl_ce_n,
  output logic             fl_we_n,
  output logic             fl_oe_n
);
  typedef enum logic [1:0] {P_IDLE, P_SETUP, P_STROBE, P_HOLD} fcsm_ph_e;

  fcsm_ph_e    ph_q, ph_d;
  logic [7:0]  cnt_q, cnt_d;
  logic        wr_q, wr_d, done_q, done_d;
  logic [15:0] rd_q, rd_d;
  logic [18:0] a_q, a_d;
  logic [15:0] dq_q, dq_d;
  logic        dqoe_n_q, dqoe_n_d, ce_n_q, ce_n_d;
  logic        we_n_q, we_n_d, oe_n_q, oe_n_d;

  // phase sequencing; we stays high on reads so oe low never looks
  // like a write, and oe stays high on writes
  always_comb begin
    ph_d = ph_q; cnt_d = cnt_q; wr_d = wr_q; done_d = 1'b0;
    rd_d = rd_q; a_d = a_q; dq_d = dq_q; dqoe_n_d = dqoe_n_q;
    ce_n_d = ce_n_q; we_n_d = we_n_q; oe_n_d = oe_n_q;
    case (ph_q)
      P_IDLE: if (start) begin
        a_d = addr; dq_d = wdata; wr_d = wr;
        dqoe_n_d = ~wr;
        ce_n_d = 1'b0;                    // ce falls first
        cnt_d = 8'(T_SETUP_CYC - 1);
        ph_d = P_SETUP;
      end
      P_SETUP: if (cnt_q == 8'h00) begin
        we_n_d = ~wr_q;                   // address taken here
        oe_n_d = wr_q;
        cnt_d = wr_q ? 8'(T_WP_CYC - 1) : 8'(T_ACC_CYC - 1);
        ph_d = P_STROBE;
      end else cnt_d = cnt_q - 8'h01;
      P_STROBE: if (cnt_q == 8'h00) begin
        we_n_d = 1'b1;                    // we rises before ce
        oe_n_d = 1'b1;
        if (!wr_q) rd_d = fl_dq_in;
        cnt_d = 8'(T_HOLD_CYC - 1);
        ph_d = P_HOLD;
      end else cnt_d = cnt_q - 8'h01;
      default: if (cnt_q == 8'h00) begin
        ce_n_d = 1'b1; dqoe_n_d = 1'b1; done_d = 1'b1;
        ph_d = P_IDLE;
      end else cnt_d = cnt_q - 8'h01;
    endcase
  end

  // registers; pins idle with every strobe high
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ph_q <= P_IDLE; cnt_q <= 8'h00; wr_q <= 1'b0; done_q <= 1'b0;
      rd_q <= 16'h0000; a_q <= 19'h00000; dq_q <= 16'h0000;
      dqoe_n_q <= 1'b1; ce_n_q <= 1'b1; we_n_q <= 1'b1; oe_n_q <= 1'b1;
    end else begin
      ph_q <= ph_d; cnt_q <= cnt_d; wr_q <= wr_d; done_q <= done_d;
      rd_q <= rd_d; a_q <= a_d; dq_q <= dq_d;
      dqoe_n_q <= dqoe_n_d; ce_n_q <= ce_n_d;
      we_n_q <= we_n_d; oe_n_q <= oe_n_d;
    end
  end

  assign done       = done_q;
  assign rdata      = rd_q;
  assign fl_addr    = a_q;
  assign fl_dq_out  = dq_q;
  assign fl_dq_oe_n = dqoe_n_q;
  assign fl_ce_n    = ce_n_q;
  assign fl_we_n    = we_n_q;
  assign fl_oe_n    = oe_n_q;
endmodule // fcsm_bus_cycle
`default_nettype wire

// [design/fcsm_host.sv]
// Purpose: host that drives a parallel NOR flash command interface
// Assumes: software orders operations over APB, one at a time
// Notes:   flash status polling uses the toggle bit
//
// The placing of the registers and the APB slave port were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module fcsm_host
  import fcsm_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // flash pins
  output logic [18:0]      fl_addr,
  output logic [15:0]      fl_dq_out,
  output logic             fl_dq_oe_n,
  input  wire logic [15:0] fl_dq_in,
  output logic             fl_ce_n,
  output logic             fl_we_n,
  output logic             fl_oe_n,
  output logic             fl_byte_n
);
  typedef enum logic [2:0] {
    S_IDLE, S_WR, S_POLL_A, S_POLL_B, S_FIX, S_WAIT, S_READ
  } fcsm_st_e;

  fcsm_st_e    st_q, st_d;
  logic [3:0]  op_q, op_d;
  logic [2:0]  idx_q, idx_d;
  logic        iss_q, iss_d;
  logic [11:0] wcnt_q, wcnt_d;
  logic [15:0] rd1_q, rd1_d, rdat_q, rdat_d;
  logic        err_q, err_d, ref_q, ref_d, byp_q, byp_d;
  logic        idm_q, idm_d, susp_q, susp_d, ers_q, ers_d;
  logic        byte_q, byte_d, bn_q, bn_d;
  logic [18:0] addr_q, addr_d;
  logic [15:0] wdat_q, wdat_d;
  logic        cs_q, cs_d, cw_q, cw_d;
  logic [18:0] ca_q, ca_d;
  logic [15:0] cd_q, cd_d;
  logic        prdy_q, prdy_d, perr_q, perr_d;
  logic [31:0] prd_q, prd_d;
  logic        cyc_done;
  logic [15:0] cyc_rdata;
  logic        acc, wr_en, go;
  logic [35:0] step;

  // one write of a command sequence: {last, address, data}
  function automatic logic [35:0] seq_step(input logic [3:0] op,
      input logic [2:0] i, input logic bm, input logic bp,
      input logic [18:0] a, input logic [15:0] d);
    logic [18:0] u1;
    logic [18:0] u2;
    u1 = bm ? UA1_BYTE : UA1_WORD;
    u2 = bm ? UA2_BYTE : UA2_WORD;
    seq_step = {1'b1, 19'h00000, CMD_RESET};   // address ignored
    if (i == 3'd0 || i == 3'd3) seq_step = {1'b0, u1, UNLOCK1};
    if (i == 3'd1 || i == 3'd4) seq_step = {1'b0, u2, UNLOCK2};
    case (op)
      OP_IDENT:  if (i == 3'd2) seq_step = {1'b1, u1, CMD_IDENT};
      OP_BYP_EN: if (i == 3'd2) seq_step = {1'b1, u1, CMD_BYP_EN};
      OP_BYP_EX: seq_step = (i == 3'd0) ? {1'b0, 19'h00000, CMD_BYP_EX0}
                                        : {1'b1, 19'h00000, CMD_BYP_EX1};
      OP_PROG: begin
        if (bp) seq_step = (i == 3'd0) ? {1'b0, 19'h00000, CMD_PROG}
                                       : {1'b1, a, d};
        else if (i == 3'd2) seq_step = {1'b0, u1, CMD_PROG};
        else if (i == 3'd3) seq_step = {1'b1, a, d};
      end
      OP_CHIP, OP_SECTOR: begin
        if (i == 3'd2) seq_step = {1'b0, u1, CMD_ESETUP};
        if (i == 3'd5) seq_step = (op == OP_CHIP)
            ? {1'b1, u1, CMD_CHIP}
            : {1'b1, a[18:12], 12'h000, CMD_SECTOR};
      end
      OP_SUSP:   seq_step = {1'b1, 19'h00000, CMD_SUSP};
      OP_RESUME: seq_step = {1'b1, 19'h00000, CMD_RESUME};
      default:   seq_step = {1'b1, 19'h00000, CMD_RESET};
    endcase
  endfunction

  // whether an operation suits the current flash mode
  function automatic logic op_ok(input logic [3:0] op, input logic idm,
      input logic ers, input logic sus, input logic bp);
    op_ok = 1'b1;
    if (idm) op_ok = (op == OP_RESET) || (op == OP_READ);
    else if (ers) op_ok = (op == OP_SUSP) || (op == OP_POLL)
                       || (op == OP_READ);
    else if (op == OP_SUSP) op_ok = 1'b0;
    else if (op == OP_RESUME) op_ok = sus;
    else if (sus) op_ok = (op != OP_IDENT) && (op != OP_CHIP)
                       && (op != OP_SECTOR);
    else if (bp) op_ok = (op == OP_PROG) || (op == OP_BYP_EX)
                      || (op == OP_READ) || (op == OP_POLL);
    else if (op == OP_BYP_EX) op_ok = 1'b0;
    if (op > OP_POLL) op_ok = 1'b0;
  endfunction

  assign acc   = psel && penable && prdy_q;
  assign wr_en = acc && pwrite;
  assign go    = wr_en && (paddr == REG_CTRL);
  assign step  = seq_step(op_q, idx_q, byte_q, byp_q, addr_q, wdat_q);

  // apb slave: one wait state, registered answer
  always_comb begin
    prdy_d = psel && penable && !prdy_q;
    perr_d = 1'b0;
    prd_d  = 32'h00000000;
    addr_d = addr_q;
    wdat_d = wdat_q;
    if (psel && penable && !prdy_q) begin
      if (paddr == REG_CTRL) prd_d = {27'h0, byte_q, op_q};
      else if (paddr == REG_ADDR) prd_d = {13'h0, addr_q};
      else if (paddr == REG_WDATA) prd_d = {16'h0, wdat_q};
      else if (paddr == REG_STAT)
        prd_d = {25'h0, ers_q, susp_q, idm_q, byp_q, ref_q, err_q,
                 st_q != S_IDLE};
      else if (paddr == REG_RDATA) prd_d = {16'h0, rdat_q};
      else perr_d = 1'b1;
    end
    if (wr_en && paddr == REG_ADDR) addr_d = pwdata[18:0];
    if (wr_en && paddr == REG_WDATA) wdat_d = pwdata[15:0];
  end

  // sequencer: expands an operation into flash bus cycles
  always_comb begin
    st_d = st_q; op_d = op_q; idx_d = idx_q; iss_d = iss_q;
    wcnt_d = wcnt_q; rd1_d = rd1_q; rdat_d = rdat_q; err_d = err_q;
    ref_d = ref_q; byp_d = byp_q; idm_d = idm_q; susp_d = susp_q;
    ers_d = ers_q; byte_d = byte_q;
    cs_d = 1'b0; cw_d = cw_q; ca_d = ca_q; cd_d = cd_q;
    // write one to clear; a new event in the same cycle wins below
    if (wr_en && paddr == REG_STAT) begin
      if (pwdata[ST_ERR]) err_d = 1'b0;
      if (pwdata[ST_REFUSED]) ref_d = 1'b0;
    end
    case (st_q)
      S_IDLE: if (go) begin
        if (op_ok(pwdata[3:0], idm_q, ers_q, susp_q, byp_q)) begin
          op_d = pwdata[3:0]; byte_d = pwdata[CTRL_BYTE];
          idx_d = 3'd0; iss_d = 1'b0;
          if (pwdata[3:0] == OP_READ) st_d = S_READ;
          else if (pwdata[3:0] == OP_POLL) st_d = S_POLL_A;
          else st_d = S_WR;
        end else ref_d = 1'b1;
      end
      S_WR: if (!iss_q) begin
        cs_d = 1'b1; cw_d = 1'b1; iss_d = 1'b1;
        ca_d = step[34:16]; cd_d = step[15:0];
      end else if (cyc_done) begin
        iss_d = 1'b0;
        if (!step[35]) idx_d = idx_q + 3'd1;
        else begin
          st_d = S_IDLE;
          case (op_q)
            OP_RESET: idm_d = 1'b0;
            OP_IDENT: idm_d = 1'b1;
            OP_BYP_EN: byp_d = 1'b1;
            OP_BYP_EX: byp_d = 1'b0;
            OP_SECTOR: ers_d = 1'b1;
            OP_RESUME: begin
              susp_d = 1'b0; ers_d = 1'b1;
            end
            OP_SUSP: begin
              wcnt_d = 12'(T_SUSP_CYC - 1); st_d = S_WAIT;
            end
            OP_PROG, OP_CHIP: st_d = S_POLL_A;
            default: st_d = S_IDLE;
          endcase
        end
      end
      S_POLL_A, S_POLL_B, S_READ: if (!iss_q) begin
        cs_d = 1'b1; cw_d = 1'b0; iss_d = 1'b1; ca_d = addr_q;
      end else if (cyc_done) begin
        iss_d = 1'b0; rdat_d = cyc_rdata;
        if (st_q == S_READ) st_d = S_IDLE;
        else if (st_q == S_POLL_A) begin
          rd1_d = cyc_rdata; st_d = S_POLL_B;
        end else if (rd1_q[DQ_TOGGLE] == cyc_rdata[DQ_TOGGLE]) begin
          st_d = S_IDLE;
          if (op_q == OP_POLL) ers_d = 1'b0;
        end else if (cyc_data_limit(cyc_rdata)) begin
          err_d = 1'b1; idx_d = 3'd0; st_d = S_FIX;
        end else st_d = S_POLL_A;
      end
      S_FIX: if (!iss_q) begin
        cs_d = 1'b1; cw_d = 1'b1; iss_d = 1'b1;
        ca_d = 19'h00000; cd_d = CMD_RESET;
      end else if (cyc_done) begin
        iss_d = 1'b0; st_d = S_IDLE;
        if (op_q == OP_POLL) ers_d = 1'b0;
      end
      default: if (wcnt_q == 12'h000) begin
        susp_d = 1'b1; ers_d = 1'b0; st_d = S_IDLE;
      end else wcnt_d = wcnt_q - 12'h001;
    endcase
    bn_d = !byte_d;                 // pin level kept in its own flop
  end

  // timing-limit flag as read back during a poll
  function automatic logic cyc_data_limit(input logic [15:0] d);
    cyc_data_limit = d[DQ_TLIMIT];
  endfunction

  // all sequencer and bus state; mode flags clear at reset
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q <= S_IDLE; op_q <= OP_READ; idx_q <= 3'd0; iss_q <= 1'b0;
      wcnt_q <= 12'h000; rd1_q <= 16'h0000; rdat_q <= 16'h0000;
      err_q <= 1'b0; ref_q <= 1'b0; byp_q <= 1'b0; idm_q <= 1'b0;
      susp_q <= 1'b0; ers_q <= 1'b0; byte_q <= CTRL_RST[CTRL_BYTE];
      addr_q <= 19'h00000; wdat_q <= 16'h0000; bn_q <= !CTRL_RST[CTRL_BYTE];
      cs_q <= 1'b0; cw_q <= 1'b0; ca_q <= 19'h00000; cd_q <= 16'h0000;
      prdy_q <= 1'b0; perr_q <= 1'b0; prd_q <= 32'h00000000;
    end else begin
      st_q <= st_d; op_q <= op_d; idx_q <= idx_d; iss_q <= iss_d;
      wcnt_q <= wcnt_d; rd1_q <= rd1_d; rdat_q <= rdat_d;
      err_q <= err_d; ref_q <= ref_d; byp_q <= byp_d; idm_q <= idm_d;
      susp_q <= susp_d; ers_q <= ers_d; byte_q <= byte_d;
      addr_q <= addr_d; wdat_q <= wdat_d; bn_q <= bn_d;
      cs_q <= cs_d; cw_q <= cw_d; ca_q <= ca_d; cd_q <= cd_d;
      prdy_q <= prdy_d; perr_q <= perr_d; prd_q <= prd_d;
    end
  end

  // pin-level cycle generator
  fcsm_bus_cycle u_cyc (
    .clk        (clk),
    .rst_n      (rst_n),
    .start      (cs_q),
    .wr         (cw_q),
    .addr       (ca_q),
    .wdata      (cd_q),
    .done       (cyc_done),
    .rdata      (cyc_rdata),
    .fl_addr    (fl_addr),
    .fl_dq_out  (fl_dq_out),
    .fl_dq_oe_n (fl_dq_oe_n),
    .fl_dq_in   (fl_dq_in),
    .fl_ce_n    (fl_ce_n),
    .fl_we_n    (fl_we_n),
    .fl_oe_n    (fl_oe_n)
  );

  assign prdata    = prd_q;
  assign pready    = prdy_q;
  assign pslverr   = perr_q;
  assign fl_byte_n = bn_q;        // low selects 8-bit width
endmodule // fcsm_host
`default_nettype wire

// [tb/fcsm_flash_model.sv]
// Purpose: behavioural flash device facing the host pins
// Assumes: clean strobes, one bus cycle at a time
// Notes:   times shortened; suspend during a program not modelled
`timescale 1ns/10ps
`default_nettype none
module fcsm_flash_model #(
  parameter logic [15:0] ID_CODE = 16'h00c3, // arbitrary value
  parameter int          PROG_T  = 20,
  parameter int          ERASE_T = 300
) (
  // host pins
  input  wire logic [18:0] fl_addr,
  input  wire logic [15:0] fl_dq_out,
  input  wire logic        fl_dq_oe_n,
  input  wire logic        fl_ce_n,
  input  wire logic        fl_we_n,
  input  wire logic        fl_oe_n,
  input  wire logic        fl_byte_n,
  // fault control and data back
  input  wire logic        inject_err,
  output logic [15:0]      dev_dq
);
  logic [15:0] mem [logic [18:0]];
  logic [15:0] dq_q = 16'h0;
  logic [18:0] lat_a;
  logic [18:0] u1;
  logic [18:0] u2;
  logic [6:0]  sa = 7'h0;
  logic        wr_on = 0, drv = 0, tog = 0, err = 0, ident = 0, byp = 0;
  logic        susp = 0, sect = 0;
  int          step = 0, pl = 0, left = 0;
  // released bus shows the inverse, never the last value
  assign dev_dq = drv ? dq_q : ~dq_q;
  assign u1 = fl_byte_n ? 19'h00555 : 19'h00aaa;
  assign u2 = fl_byte_n ? 19'h002aa : 19'h00555;
  // embedded algorithms run on their own 100 ns tick
  always begin
    #100;
    if (pl > 0) pl--;
    else if (left > 0 && !susp) begin
      left--;
      if (left == 0) sect = 0;
    end
  end
  // read: status while busy, suspended sector or id, else array
  always @(negedge fl_oe_n) if (!fl_ce_n) begin
    drv = 1;
    if (err || pl > 0 || (left > 0 && !susp)) begin
      tog = !tog;
      dq_q = {9'h0, tog, err, 5'h0};
    end
    else if (susp && fl_addr[18:12] == sa) dq_q = 16'h0040;
    else if (ident) dq_q = ID_CODE;
    else dq_q = mem.exists(fl_addr) ? mem[fl_addr] : 16'hffff;
  end
  always @(posedge fl_oe_n or posedge fl_ce_n) drv = 0;
  // address at the later fall, data at the earlier rise
  always @(negedge fl_we_n or negedge fl_ce_n)
    if (!fl_we_n && !fl_ce_n && fl_oe_n) begin
      lat_a = fl_addr;
      wr_on = 1;
    end
  always @(posedge fl_we_n or posedge fl_ce_n) if (wr_on) begin
    wr_on = 0;
    cmd(lat_a, fl_dq_oe_n ? ~dq_q : fl_dq_out);
  end
  task automatic prog(input logic [18:0] a, input logic [15:0] d);
    if (inject_err) err = 1;
    else begin
      if (!mem.exists(a)) mem[a] = 16'hffff;
      mem[a] = mem[a] & (fl_byte_n ? d : {8'hff, d[7:0]});
      pl = PROG_T;
    end
  endtask
  // command interpreter; any odd cycle falls back to step 0, id mode and fault stay
  task automatic cmd(input logic [18:0] a, input logic [15:0] dd);
    logic [7:0] d;
    d = dd[7:0];
    if (err) begin
      if (d == 8'hf0) err = 0;
    end
    else if (pl > 0 || (left > 0 && !susp)) begin
      if (sect && d == 8'hb0) susp <= #5000 1'b1;
    end
    else if (d == 8'hf0 && step != 3 && step != 10) begin
      step = 0;
      ident = 0;
    end
    else case (step)
      0: if (byp && d == 8'ha0) step = 10;
        else if (byp && d == 8'h90) step = 11;
        else if (susp && d == 8'h30) susp = 0;
        else if (a == u1 && d == 8'haa) step = 1;
      1, 5: step = (a == u2 && d == 8'h55) ? step + 1 : 0;
      2: begin
        step = 0;
        if (a == u1 && d == 8'ha0) step = 3;
        if (a == u1 && d == 8'h90) ident = !susp;
        if (a == u1 && d == 8'h20) byp = 1;
        if (a == u1 && d == 8'h80) step = 4;
      end
      3, 10: begin
        prog(a, dd);
        step = 0;
      end
      4: step = (a == u1 && d == 8'haa) ? 5 : 0;
      6: begin
        step = 0;
        if (d == 8'h10 && a == u1) mem.delete();
        if (d == 8'h30) begin
          sa = a[18:12];
          sect = 1;
          foreach (mem[k]) if (k[18:12] == sa) mem[k] = 16'hffff;
        end
        if (d == 8'h10 || d == 8'h30) left = ERASE_T;
      end
      11: begin
        if (d == 8'h00) byp = 0;
        step = 0;
      end
      default: step = 0;
    endcase
  endtask
endmodule // fcsm_flash_model
`default_nettype wire

// [tb/fcsm_host_props.sv]
// Purpose: pin-level checks of the flash host
// Assumes: one clock, synchronous active-low reset
// Notes:   bound onto every fcsm_host instance
`timescale 1ns/10ps
`default_nettype none
module fcsm_host_props (
  // clock, reset and apb
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic        pslverr,
  // flash pins
  input wire logic [18:0] fl_addr,
  input wire logic [15:0] fl_dq_out,
  input wire logic        fl_dq_oe_n,
  input wire logic        fl_ce_n,
  input wire logic        fl_we_n,
  input wire logic        fl_oe_n,
  input wire logic        fl_byte_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // strobe combinations on the flash bus
  a_write_oe_high: assert property (!fl_we_n |-> !fl_ce_n && fl_oe_n)
    else $error("write strobe with oe low");
  a_read_undriven: assert property (!fl_oe_n |-> fl_dq_oe_n && fl_we_n)
    else $error("read while host drives dq");
  a_write_drives_dq: assert property (!fl_we_n |-> !fl_dq_oe_n)
    else $error("write strobe without data");
  a_idle_released: assert property (fl_ce_n |-> fl_we_n && fl_oe_n)
    else $error("strobe outside chip enable");
  // widths and framing per the hand-over timing
  a_we_pulse_width: assert property ($fell(fl_we_n) |-> !fl_we_n [*4] ##1 fl_we_n)
    else $error("we pulse width wrong");
  a_ce_after_we: assert property ($rose(fl_we_n) |-> !fl_ce_n ##1 !fl_ce_n)
    else $error("ce rose too early after we");
  a_addr_held_cycle: assert property (!fl_ce_n && !$past(fl_ce_n)
    |-> $stable(fl_addr) && $stable(fl_dq_out) && $stable(fl_byte_n))
    else $error("address or data moved in cycle");
  a_oe_pulse_width: assert property ($fell(fl_oe_n) |-> !fl_oe_n [*7] ##1 fl_oe_n)
    else $error("oe pulse width wrong");
  c_write: cover property ($rose(fl_we_n));
  c_read: cover property ($rose(fl_oe_n));
  c_slverr: cover property (psel && penable && pready && pslverr);
endmodule // fcsm_host_props
bind fcsm_host fcsm_host_props fcsm_host_props_inst (.clk(clk),
  .rst_n(rst_n), .psel(psel), .penable(penable), .pready(pready),
  .pslverr(pslverr), .fl_addr(fl_addr), .fl_dq_out(fl_dq_out),
  .fl_dq_oe_n(fl_dq_oe_n), .fl_ce_n(fl_ce_n), .fl_we_n(fl_we_n),
  .fl_oe_n(fl_oe_n), .fl_byte_n(fl_byte_n));
`default_nettype wire

// [tb/tb_top.sv]
// Purpose: self-checking bench of the flash host
// Assumes: host answers apb with one wait state
// Notes:   flash model runs shortened algorithm times
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import fcsm_pkg::*;
  logic        clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = 8'h0;
  logic [31:0] pwdata = 32'h0, prdata;
  logic        pready, pslverr, dq_oe_n, ce_n, we_n, oe_n, byte_n;
  logic        inj = 0;
  logic [18:0] fa;
  logic [15:0] dq_o, dev_dq, dq_i;
  int          fails = 0, check_count = 0;
  always #5 clk = !clk;
  // the shared data wire seen by the host
  assign dq_i = dq_oe_n ? dev_dq : dq_o;
  fcsm_host fcsm_host_inst (.clk(clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .fl_addr(fa),
    .fl_dq_out(dq_o), .fl_dq_oe_n(dq_oe_n), .fl_dq_in(dq_i),
    .fl_ce_n(ce_n), .fl_we_n(we_n), .fl_oe_n(oe_n), .fl_byte_n(byte_n));
  fcsm_flash_model fcsm_flash_model_inst (.fl_addr(fa), .fl_dq_out(dq_o),
    .fl_dq_oe_n(dq_oe_n), .fl_ce_n(ce_n), .fl_we_n(we_n), .fl_oe_n(oe_n),
    .fl_byte_n(byte_n), .inject_err(inj), .dev_dq(dev_dq));
  task automatic report_and_stop;
    if (fails == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // one apb transfer, entered just after a rising edge
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] r, output logic e);
    int n;
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    r = prdata;
    e = pslverr;
    if (n >= 20) begin
      fails++;
      $display("BAD %0t no pready", $time);
    end
    psel <= 0;
    penable <= 0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1, a, d, r, e);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    logic e;
    apb(0, a, 32'h0, r, e);
  endtask
  // issue one operation, then wait for busy to drop
  task automatic go(input logic [3:0] o, input logic [18:0] a,
    input logic [15:0] d, input logic b);
    int n;
    logic [31:0] s;
    wr(REG_ADDR, {13'h0, a});
    wr(REG_WDATA, {16'h0, d});
    wr(REG_CTRL, {27'h0, b, o});
    n = 0;
    do begin
      rd(REG_STAT, s);
      n++;
    end while (s[ST_BUSY] !== 1'b0 && n < 3000);
    if (n >= 3000) begin
      fails++;
      $display("BAD %0t busy stuck", $time);
    end
  endtask
  task automatic rdf(input logic [18:0] a, input logic [31:0] exp);
    logic [31:0] r;
    go(OP_READ, a, 16'h0, 1'b0);
    rd(REG_RDATA, r);
    chk(r, exp);
  endtask
  task automatic stat(input int bit_no, input logic v);
    logic [31:0] s;
    rd(REG_STAT, s);
    chk({31'h0, s[bit_no]}, {31'h0, v});
  endtask
  task automatic t_basic;
    logic [31:0] r;
    logic e;
    stat(ST_BUSY, 0);
    apb(0, 8'h14, 32'h0, r, e);
    chk({r[30:0], e}, 32'h1);
    rdf(19'h00100, 32'hffff);
    go(OP_PROG, 19'h00100, 16'h1234, 1'b0);
    rdf(19'h00100, 32'h1234);
    go(OP_PROG, 19'h00100, 16'h0056, 1'b1);
    rdf(19'h00100, 32'h1214);
  endtask
  task automatic t_modes;
    go(OP_IDENT, 19'h0, 16'h0, 1'b0);
    stat(ST_IDENT, 1);
    rdf(19'h0, 32'h00c3);
    rdf(19'h0, 32'h00c3);
    go(OP_RESET, 19'h0, 16'h0, 1'b0);
    rdf(19'h00100, 32'h1214);
    go(OP_BYP_EN, 19'h0, 16'h0, 1'b0);
    stat(ST_BYPASS, 1);
    go(OP_PROG, 19'h00104, 16'hbeef, 1'b0);
    go(OP_BYP_EX, 19'h0, 16'h0, 1'b0);
    stat(ST_BYPASS, 0);
    rdf(19'h00104, 32'hbeef);
  endtask
  task automatic t_sector;
    logic [31:0] s;
    int n;
    go(OP_PROG, 19'h03004, 16'h0, 1'b0);
    go(OP_SECTOR, 19'h03000, 16'h0, 1'b0);
    stat(ST_ERASING, 1);
    go(OP_SUSP, 19'h0, 16'h0, 1'b0);
    stat(ST_SUSP, 1);
    rdf(19'h00100, 32'h1214);
    go(OP_READ, 19'h03008, 16'h0, 1'b0);
    rd(REG_RDATA, s);
    chk({31'h0, s[7]}, 32'h0);
    go(OP_IDENT, 19'h0, 16'h0, 1'b0);
    stat(ST_IDENT, 0);
    stat(ST_REFUSED, 1);
    go(OP_RESUME, 19'h0, 16'h0, 1'b0);
    stat(ST_SUSP, 0);
    n = 0;
    do begin
      go(OP_POLL, 19'h03000, 16'h0, 1'b0);
      rd(REG_STAT, s);
      n++;
    end while (s[ST_ERASING] !== 1'b0 && n < 300);
    rdf(19'h03004, 32'hffff);
  endtask
  task automatic t_fault;
    inj <= 1;
    go(OP_PROG, 19'h00108, 16'h1111, 1'b0);
    inj <= 0;
    stat(ST_ERR, 1);
    wr(REG_STAT, 32'h6);
    stat(ST_ERR, 0);
    rdf(19'h00100, 32'h1214);
    go(OP_CHIP, 19'h0, 16'h0, 1'b0);
    stat(ST_REFUSED, 0);
    wr(REG_CTRL, {28'h0, OP_SUSP});
    go(OP_CHIP, 19'h0, 16'h0, 1'b0);
    wr(REG_CTRL, {28'h0, OP_SUSP});
    stat(ST_REFUSED, 1);
    go(OP_READ, 19'h0, 16'h0, 1'b0);
    rdf(19'h00100, 32'hffff);
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1;
    @(posedge clk);
    t_basic;
    t_modes;
    t_sector;
    t_fault;
    report_and_stop;
  end
  // watchdog well beyond the expected run of some 13k cycles
  initial begin
    #900000;
    fails++;
    report_and_stop;
  end
endmodule // tb_top
`default_nettype wire
